// [sbf_serial_baud_and_fifo_config.sv]
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Behaviour
// - bits 5-4 pick the prescaler tap T1, T4, T16 or T64.
// - divisor codes 1 to 15 mean N directly, code 0 means 16.
// - fraction enable at bit 6 gives N+(16-K)/16, UART mode only.
// - FIFO on gives 4-byte half-duplex FIFO or 2+2 bytes in full duplex.
// - transmit FIFO interrupt enable gates transmit FIFO interrupts; the transmit auto-disable event is not gated.
// - auto-disable clears receive and/or transmit enable on full or empty.
// - transmit FIFO level counts bytes written less bytes popped, capped at the configured depth.
module sbf_serial_baud_and_fifo_config import sbf_pkg::*; #(
   parameter int DEPTH_W = 3
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_store_full,
   input wire logic tx_all_empty,
   input wire logic tx_push,
   input wire logic tx_pop,
   input wire logic rx_fifo_event,
   input wire logic tx_fifo_event,
   output logic baud_tick,
   output logic rx_enable,
   output logic tx_enable,
   output logic [DEPTH_W-1:0] rx_fifo_depth,
   output logic [DEPTH_W-1:0] tx_fifo_depth,
   output logic [DEPTH_W-1:0] tx_fifo_level,
   output logic rx_fifo_irq,
   output logic tx_fifo_irq,
   output logic irq
);
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic sbf_hit(input logic [7:0] adr, input logic [7:0] off);
      return adr == off;
   endfunction : sbf_hit

   function automatic logic sbf_tap(input logic [1:0] sel, input logic [5:0] pre);
      logic t;
      t = 1'b0;
      case (sel)
         SBF_TAP_T1: t = 1'b1;
         SBF_TAP_T4: t = &pre[1:0];
         SBF_TAP_T16: t = &pre[3:0];
         SBF_TAP_T64: t = &pre;
         default: t = 1'b0;
      endcase
      return t;
   endfunction : sbf_tap

   logic [7:0] brc_q;
   logic [3:0] brk_q;
   logic [7:0] fcnf_q;
   logic [3:0] chan_q;
   logic [3:0] ev_q;
   logic [3:0] mask_q;
   logic [5:0] pre_q;
   logic tap_q;
   logic rxf_prev_q;
   logic txe_prev_q;
   logic req;
   logic wr;
   logic [31:0] rd_d;
   logic [3:0] ev_set;
   logic rx_hit;
   logic tx_hit;
   logic clr_rx;
   logic clr_tx;
   sbf_duplex_t dup;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // all writable fields live in byte lane 0
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign dup = sbf_duplex_t'(chan_q[SBF_CH_DUP_LSB +: 2]);

   // ----------------------------------------
   // bus slave, one wait state
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_d : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (sbf_hit(wb_adr_i, SBF_OFF_BRC)) begin
         rd_d[7:0] = brc_q;
      end else if (sbf_hit(wb_adr_i, SBF_OFF_BRK)) begin
         rd_d[3:0] = brk_q;
      end else if (sbf_hit(wb_adr_i, SBF_OFF_FCNF)) begin
         rd_d[7:0] = fcnf_q;
      end else if (sbf_hit(wb_adr_i, SBF_OFF_CHAN)) begin
         rd_d[5:0] = {tx_enable, rx_enable, chan_q};
      end else if (sbf_hit(wb_adr_i, SBF_OFF_STAT)) begin
         rd_d[2:0] = 3'(rx_fifo_depth);
         rd_d[6:4] = 3'(tx_fifo_depth);
         rd_d[10:8] = 3'(tx_fifo_level);
      end else if (sbf_hit(wb_adr_i, SBF_OFF_IRQ)) begin
         rd_d[3:0] = ev_q;
      end else if (sbf_hit(wb_adr_i, SBF_OFF_MASK)) begin
         rd_d[3:0] = mask_q;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         brc_q <= SBF_BRC_RST;
         brk_q <= SBF_BRK_RST;
         fcnf_q <= SBF_FCNF_RST;
         chan_q <= SBF_CHAN_RST;
         mask_q <= SBF_EV_RST;
      end else if (wr) begin
         if (sbf_hit(wb_adr_i, SBF_OFF_BRC)) begin
            brc_q <= wb_dat_i[7:0];
         end
         if (sbf_hit(wb_adr_i, SBF_OFF_BRK)) begin
            brk_q <= wb_dat_i[3:0];
         end
         // bits 7-5 are stored as written; software keeps them zero
         if (sbf_hit(wb_adr_i, SBF_OFF_FCNF)) begin
            fcnf_q <= wb_dat_i[7:0];
         end
         if (sbf_hit(wb_adr_i, SBF_OFF_CHAN)) begin
            chan_q <= wb_dat_i[3:0];
         end
         if (sbf_hit(wb_adr_i, SBF_OFF_MASK)) begin
            mask_q <= wb_dat_i[3:0];
         end
      end
   end

   // ----------------------------------------
   // prescaler and baud divider
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre_q <= 6'h00;
         tap_q <= 1'b0;
      end else begin
         pre_q <= 6'(pre_q + 6'h01);
         tap_q <= sbf_tap(brc_q[SBF_BRC_CK_LSB +: 2], pre_q);
      end
   end

   // fraction forced off outside UART mode
   sbf_baud_div u_div (
      .clock(clock),
      .rstn(rstn),
      .tick_i(tap_q),
      .n_code_i(brc_q[SBF_BRC_N_LSB +: 4]),
      .k_i(brk_q),
      .frac_en_i(brc_q[SBF_BRC_FRAC] && chan_q[SBF_CH_UART]),
      .baud_tick_o(baud_tick)
   );

   // ----------------------------------------
   // fifo split
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_fifo_depth <= '0;
         tx_fifo_depth <= '0;
      end else if (!fcnf_q[SBF_FC_CNFG]) begin
         rx_fifo_depth <= '0;
         tx_fifo_depth <= '0;
      end else begin
         case (dup)
            SBF_DUP_HALF_RX: begin
               rx_fifo_depth <= DEPTH_W'(SBF_HALF_DEPTH);
               tx_fifo_depth <= '0;
            end
            SBF_DUP_HALF_TX: begin
               rx_fifo_depth <= '0;
               tx_fifo_depth <= DEPTH_W'(SBF_HALF_DEPTH);
            end
            SBF_DUP_FULL: begin
               rx_fifo_depth <= DEPTH_W'(SBF_FULL_DEPTH);
               tx_fifo_depth <= DEPTH_W'(SBF_FULL_DEPTH);
            end
            default: begin
               rx_fifo_depth <= '0;
               tx_fifo_depth <= '0;
            end
         endcase
      end
   end

   // level tracks writes; pushes beyond depth are dropped
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_fifo_level <= '0;
      end else if (tx_fifo_depth == '0) begin
         tx_fifo_level <= '0;
      end else begin
         case ({tx_push && tx_fifo_level < tx_fifo_depth, tx_pop && tx_fifo_level != '0})
            2'b10: tx_fifo_level <= DEPTH_W'(tx_fifo_level + 1'b1);
            2'b01: tx_fifo_level <= DEPTH_W'(tx_fifo_level - 1'b1);
            default: tx_fifo_level <= tx_fifo_level;
         endcase
      end
   end

   // ----------------------------------------
   // enables with automatic disable
   // ----------------------------------------
   // act on the edge so an idle empty line does not kill a fresh enable
   assign rx_hit = rx_store_full && !rxf_prev_q && (dup == SBF_DUP_HALF_RX || dup == SBF_DUP_FULL);
   assign tx_hit = tx_all_empty && !txe_prev_q && (dup == SBF_DUP_HALF_TX || dup == SBF_DUP_FULL);
   assign clr_rx = fcnf_q[SBF_FC_AUTO] && (rx_hit || (dup == SBF_DUP_FULL && tx_hit));
   assign clr_tx = fcnf_q[SBF_FC_AUTO] && (tx_hit || (dup == SBF_DUP_FULL && rx_hit));

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxf_prev_q <= 1'b0;
         // idle transmitter reads empty; start high so no false edge
         txe_prev_q <= 1'b1;
      end else begin
         rxf_prev_q <= rx_store_full;
         txe_prev_q <= tx_all_empty;
      end
   end

   // hardware clear beats a software write in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_enable <= 1'b0;
         tx_enable <= 1'b0;
      end else begin
         if (clr_rx) begin
            rx_enable <= 1'b0;
         end else if (wr && sbf_hit(wb_adr_i, SBF_OFF_CHAN)) begin
            rx_enable <= wb_dat_i[SBF_CH_RXE];
         end
         if (clr_tx) begin
            tx_enable <= 1'b0;
         end else if (wr && sbf_hit(wb_adr_i, SBF_OFF_CHAN)) begin
            tx_enable <= wb_dat_i[SBF_CH_TXE];
         end
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_fifo_irq <= 1'b0;
         tx_fifo_irq <= 1'b0;
      end else begin
         rx_fifo_irq <= rx_fifo_event && fcnf_q[SBF_FC_RX_FIFO_IRQ_ENABLE] && rx_fifo_depth != '0;
         tx_fifo_irq <= tx_fifo_event && fcnf_q[SBF_FC_TX_FIFO_IRQ_ENABLE] && tx_fifo_depth != '0;
      end
   end

   always_comb begin
      ev_set = 4'h0;
      ev_set[SBF_EV_RXF] = rx_fifo_irq;
      ev_set[SBF_EV_TXF] = tx_fifo_irq;
      ev_set[SBF_EV_RXOFF] = clr_rx && rx_enable;
      ev_set[SBF_EV_TXOFF] = clr_tx && tx_enable;
   end

   // write one to clear; a new event in the same cycle stays set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ev_q <= SBF_EV_RST;
         irq <= 1'b0;
      end else begin
         if (wr && sbf_hit(wb_adr_i, SBF_OFF_IRQ)) begin
            ev_q <= (ev_q & ~wb_dat_i[3:0]) | ev_set;
         end else begin
            ev_q <= ev_q | ev_set;
         end
         irq <= |(ev_q & mask_q);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   tap_t4_gap_a: assert property (@(posedge clock) disable iff (!rstn)
      (brc_q[5:4] == 2'b01 && tap_q && $stable(brc_q)) |=> !tap_q [*3])
      else $error("T4 tap fired within four cycles");
   tap_t1_run_a: assert property (@(posedge clock) disable iff (!rstn)
      (brc_q[5:4] == 2'b00 && $past(brc_q[5:4]) == 2'b00 && $past(rstn)) |-> tap_q)
      else $error("T1 tap missing");
   full_split_a: assert property (@(posedge clock) disable iff (!rstn)
      ($past(fcnf_q[0]) && $past(chan_q[2:1]) == 2'b10) |-> (rx_fifo_depth == 3'd2 && tx_fifo_depth == 3'd2))
      else $error("full duplex split not 2+2");
   half_rx_depth_a: assert property (@(posedge clock) disable iff (!rstn)
      ($past(fcnf_q[0]) && $past(chan_q[2:1]) == 2'b00) |-> (rx_fifo_depth == 3'd4 && tx_fifo_depth == 3'd0))
      else $error("half duplex receive depth not 4");
   tx_irq_gate_a: assert property (@(posedge clock) disable iff (!rstn)
      tx_fifo_irq |-> $past(fcnf_q[3] && tx_fifo_event))
      else $error("transmit interrupt without enable");
   rx_irq_gate_a: assert property (@(posedge clock) disable iff (!rstn)
      (rx_fifo_event && !fcnf_q[2]) |=> !rx_fifo_irq)
      else $error("receive interrupt while disabled");
   auto_rx_off_a: assert property (@(posedge clock) disable iff (!rstn)
      (fcnf_q[1] && chan_q[2:1] == 2'b00 && rx_store_full && !rxf_prev_q) |=> !rx_enable)
      else $error("receive enable not cleared on full");
   auto_full_off_a: assert property (@(posedge clock) disable iff (!rstn)
      (fcnf_q[1] && chan_q[2:1] == 2'b10 && tx_all_empty && !txe_prev_q) |=> (!rx_enable && !tx_enable))
      else $error("full duplex enables not both cleared");
   tx_level_inc_a: assert property (@(posedge clock) disable iff (!rstn)
      (tx_push && !tx_pop && tx_fifo_level < tx_fifo_depth && $stable(tx_fifo_depth))
      |=> tx_fifo_level == $past(tx_fifo_level) + 3'd1)
      else $error("transmit level missed a write");
   irq_follow_a: assert property (@(posedge clock) disable iff (!rstn)
      irq == $past(|(ev_q & mask_q)))
      else $error("interrupt output wrong");
endmodule : sbf_serial_baud_and_fifo_config

// [sbf_pkg.sv]
package sbf_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] SBF_OFF_BRC = 8'h00;
   localparam logic [7:0] SBF_OFF_BRK = 8'h04;
   localparam logic [7:0] SBF_OFF_FCNF = 8'h08;
   localparam logic [7:0] SBF_OFF_CHAN = 8'h0C;
   localparam logic [7:0] SBF_OFF_STAT = 8'h10;
   localparam logic [7:0] SBF_OFF_IRQ = 8'h14;
   localparam logic [7:0] SBF_OFF_MASK = 8'h18;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SBF_BRC_N_LSB = 0;
   localparam int SBF_BRC_CK_LSB = 4;
   localparam int SBF_BRC_FRAC = 6;
   localparam int SBF_FC_CNFG = 0;
   localparam int SBF_FC_AUTO = 1;
   localparam int SBF_FC_RX_FIFO_IRQ_ENABLE = 2;
   localparam int SBF_FC_TX_FIFO_IRQ_ENABLE = 3;
   localparam int SBF_FC_RX_FIFO_BYTE_USE_SELECT = 4;
   localparam int SBF_CH_UART = 0;
   localparam int SBF_CH_DUP_LSB = 1;
   localparam int SBF_CH_DBUF = 3;
   localparam int SBF_CH_RXE = 4;
   localparam int SBF_CH_TXE = 5;
   localparam int SBF_EV_RXF = 0;
   localparam int SBF_EV_TXF = 1;
   localparam int SBF_EV_RXOFF = 2;
   localparam int SBF_EV_TXOFF = 3;
   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam logic [7:0] SBF_BRC_RST = 8'h00;
   localparam logic [3:0] SBF_BRK_RST = 4'h0;
   localparam logic [7:0] SBF_FCNF_RST = 8'h00;
   localparam logic [3:0] SBF_CHAN_RST = 4'h0;
   localparam logic [3:0] SBF_EV_RST = 4'h0;
   localparam int SBF_HALF_DEPTH = 4;
   localparam int SBF_FULL_DEPTH = 2;
   localparam int SBF_FRAC_RUN = 16;
   // ----------------------------------------
   // prescaler taps and duplex modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      SBF_TAP_T1 = 2'b00,
      SBF_TAP_T4 = 2'b01,
      SBF_TAP_T16 = 2'b10,
      SBF_TAP_T64 = 2'b11
   } sbf_tap_t;
   typedef enum logic [1:0] {
      SBF_DUP_HALF_RX = 2'b00,
      SBF_DUP_HALF_TX = 2'b01,
      SBF_DUP_FULL = 2'b10,
      SBF_DUP_RSVD = 2'b11
   } sbf_duplex_t;
endpackage : sbf_pkg

// [sbf_baud_div.sv]
`timescale 1ns/1ps
module sbf_baud_div import sbf_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic tick_i,
   input wire logic [3:0] n_code_i,
   input wire logic [3:0] k_i,
   input wire logic frac_en_i,
   output logic baud_tick_o
);
   logic [4:0] cnt_q;
   logic [3:0] acc_q;
   logic str_q;
   logic [4:0] n_val;
   logic [4:0] last;
   logic [4:0] sum;
   logic wrap;
   logic [4:0] seen_q;
   logic chg_q;

   // code zero stands for sixteen
   assign n_val = (n_code_i == 4'h0) ? 5'(SBF_FRAC_RUN) : {1'b0, n_code_i};
   assign last = 5'(n_val - 5'h01 + {4'h0, str_q});
   assign sum = 5'({1'b0, acc_q} + 5'(5'(SBF_FRAC_RUN) - {1'b0, k_i}));
   assign wrap = tick_i && (cnt_q == last);

   // ----------------------------------------
   // period counter
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 5'h00;
      end else if (wrap) begin
         cnt_q <= 5'h00;
      end else if (tick_i) begin
         cnt_q <= 5'(cnt_q + 5'h01);
      end
   end

   // accumulator spreads 16-K stretched periods over each run of 16
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acc_q <= 4'h0;
         str_q <= 1'b0;
      end else if (wrap) begin
         if (frac_en_i) begin
            acc_q <= sum[3:0];
            str_q <= sum[4];
         end else begin
            acc_q <= 4'h0;
            str_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         baud_tick_o <= 1'b0;
      end else begin
         baud_tick_o <= wrap;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seen_q <= 5'h00;
         chg_q <= 1'b1;
      end else begin
         if (wrap) begin
            seen_q <= 5'h00;
         end else if (tick_i) begin
            seen_q <= 5'(seen_q + 5'h01);
         end
         if (wrap) begin
            chg_q <= 1'b0;
         end else if ($changed(n_code_i) || $changed(frac_en_i)) begin
            chg_q <= 1'b1;
         end
      end
   end

   int_period_a: assert property (@(posedge clock) disable iff (!rstn)
      (wrap && !chg_q && !frac_en_i) |-> (5'(seen_q + 5'h01) == n_val))
      else $error("integer period differs from N");
   frac_period_a: assert property (@(posedge clock) disable iff (!rstn)
      (wrap && !chg_q && frac_en_i) |-> (seen_q + 5'h01 == n_val || seen_q == n_val))
      else $error("fractional period not N or N+1");
   tick_follows_a: assert property (@(posedge clock) disable iff (!rstn)
      baud_tick_o == $past(wrap))
      else $error("baud tick does not follow wrap");
endmodule : sbf_baud_div

// [sbf_line_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// engine side: fifo strobes and shift status
// ----------------------------------------
module sbf_line_model (
   input wire logic clock,
   output logic rx_store_full,
   output logic tx_all_empty,
   output logic tx_push,
   output logic tx_pop,
   output logic rx_fifo_event,
   output logic tx_fifo_event
);
   initial begin
      {rx_store_full, tx_all_empty, tx_push, tx_pop, rx_fifo_event, tx_fifo_event} = 6'h00;
   end
   // one-clock strobe; an idle edge follows so back-to-back calls never merge
   task automatic strobe(input int which);
      @(posedge clock);
      case (which)
         0: tx_push <= 1'b1;
         1: tx_pop <= 1'b1;
         2: rx_fifo_event <= 1'b1;
         default: tx_fifo_event <= 1'b1;
      endcase
      @(posedge clock);
      {tx_push, tx_pop, rx_fifo_event, tx_fifo_event} <= 4'h0;
   endtask : strobe
   task automatic levels(input logic full, input logic empty);
      @(posedge clock);
      rx_store_full <= full;
      tx_all_empty <= empty;
   endtask : levels
endmodule : sbf_line_model

// [tb.sv]
`timescale 1ns/1ps
module tb import sbf_pkg::*; ;
   localparam int LIMIT = 80000;
   localparam int TAPF [4] = '{1, 4, 16, 64};
   logic clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [3:0] sel_v;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic rx_store_full, tx_all_empty, tx_push, tx_pop, rx_fifo_event, tx_fifo_event;
   logic baud_tick, rx_enable, tx_enable, rx_fifo_irq, tx_fifo_irq, irq;
   logic [2:0] rx_fifo_depth, tx_fifo_depth, tx_fifo_level;
   logic [31:0] rd_q [$];
   logic [7:0] offs [8];
   int failures, samples_checked, cycles, rxi, txi, i, n, k, m, d, dup;
   sbf_serial_baud_and_fifo_config #(.DEPTH_W(3)) dut (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_store_full(rx_store_full), .tx_all_empty(tx_all_empty),
      .tx_push(tx_push), .tx_pop(tx_pop), .rx_fifo_event(rx_fifo_event), .tx_fifo_event(tx_fifo_event),
      .baud_tick(baud_tick), .rx_enable(rx_enable), .tx_enable(tx_enable), .rx_fifo_depth(rx_fifo_depth),
      .tx_fifo_depth(tx_fifo_depth), .tx_fifo_level(tx_fifo_level), .rx_fifo_irq(rx_fifo_irq),
      .tx_fifo_irq(tx_fifo_irq), .irq(irq));
   sbf_line_model line (.clock(clock), .rx_store_full(rx_store_full), .tx_all_empty(tx_all_empty),
      .tx_push(tx_push), .tx_pop(tx_pop), .rx_fifo_event(rx_fifo_event), .tx_fifo_event(tx_fifo_event));
   always #2 clock = ~clock;
   // ----------------------------------------
   // compare, report, hang guard
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end
   // read data is compared at the ack edge against the oldest note
   always @(posedge clock) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) chk("read data", rd_q.pop_front(), wb_dat_o);
      if (rx_fifo_irq === 1'b1) rxi++;
      if (tx_fifo_irq === 1'b1) txi++;
   end
   // ----------------------------------------
   // bus master and baud measurement
   // ----------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= sel_v;
      wb_dat_i <= dat;
      // only the bench timeout ends this wait
      do begin
         @(posedge clock);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      bus(1'b1, a, dat);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   // two ticks are skipped: the divider phase after a rewrite is not defined
   task automatic ticks(input int cnt, output int cyc);
      int c;
      c = 0;
      cyc = 0;
      repeat (2) begin
         do begin @(posedge clock); cyc++; end while (baud_tick !== 1'b1 && cyc < 5000);
      end
      cyc = 0;
      while (c < cnt && cyc < 20000) begin
         @(posedge clock);
         cyc++;
         if (baud_tick === 1'b1) c++;
      end
   endtask : ticks
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      sel_v = 4'hF;
      wb_dat_i = 32'h0;
      offs = '{SBF_OFF_BRC, SBF_OFF_BRK, SBF_OFF_FCNF, SBF_OFF_CHAN, SBF_OFF_STAT, SBF_OFF_IRQ, SBF_OFF_MASK, 8'h1C};
      void'($urandom(9240));
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      for (i = 0; i < 8; i++) rd(offs[i], 32'h0);
      k = $urandom_range(15, 1);
      wr(SBF_OFF_BRK, 32'hFFFF_FFF0 | k);
      rd(SBF_OFF_BRK, 32'(k));
      // byte lane 0 not selected: the write must be ignored
      sel_v = 4'($urandom_range(7, 1) * 2);
      wr(SBF_OFF_BRK, 32'($urandom) | 32'h0000_0001);
      sel_v = 4'hF;
      rd(SBF_OFF_BRK, 32'(k));
      n = $urandom_range(31, 0);
      wr(SBF_OFF_FCNF, 32'(n));
      rd(SBF_OFF_FCNF, 32'(n));
      wr(SBF_OFF_FCNF, 32'h0);
      // every tap, random N, code zero meaning sixteen
      for (i = 0; i < 4; i++) begin
         n = (i == 3) ? 0 : $urandom_range(15, 2);
         wr(SBF_OFF_BRC, 32'(i * 16 + n));
         ticks(2, m);
         chk("baud period", 32'(TAPF[i] * ((n == 0) ? 16 : n) * 2), 32'(m));
      end
      wr(SBF_OFF_CHAN, 32'h1);
      n = $urandom_range(15, 2);
      k = $urandom_range(15, 1);
      wr(SBF_OFF_BRK, 32'(k));
      wr(SBF_OFF_BRC, 32'h40 | n);
      ticks(16, m);
      chk("fraction sum", 32'(16 * n + 16 - k), 32'(m));
      wr(SBF_OFF_CHAN, 32'h0);
      ticks(16, m);
      chk("io mode sum", 32'(16 * n), 32'(m));
      // split per duplex; pass 3 has the fifo off, pass 4 the unused duplex code
      for (d = 0; d < 5; d++) begin
         dup = (d == 3) ? 2 : (d == 4) ? 3 : d;
         wr(SBF_OFF_CHAN, 32'(dup * 2));
         wr(SBF_OFF_FCNF, 32'(d != 3));
         repeat (2) @(posedge clock);
         n = (d == 0) ? 4 : (d == 2) ? 2 : 0;
         k = (d == 1) ? 4 : (d == 2) ? 2 : 0;
         chk("rx depth", 32'(n), 32'(rx_fifo_depth));
         chk("tx depth", 32'(k), 32'(tx_fifo_depth));
         rd(SBF_OFF_STAT, 32'(k * 16 + n));
      end
      wr(SBF_OFF_CHAN, 32'h2);
      wr(SBF_OFF_FCNF, 32'h1);
      repeat (5) line.strobe(0);
      @(posedge clock);
      chk("tx level full", 32'h4, 32'(tx_fifo_level));
      line.strobe(1);
      @(posedge clock);
      chk("tx level", 32'h3, 32'(tx_fifo_level));
      rd(SBF_OFF_STAT, 32'h340);
      // gated fifo events, mask and write-one-clear
      wr(SBF_OFF_CHAN, 32'h4);
      wr(SBF_OFF_FCNF, 32'h5);
      wr(SBF_OFF_MASK, 32'h3);
      line.strobe(2);
      line.strobe(3);
      repeat (3) @(posedge clock);
      chk("rx irq count", 32'h1, 32'(rxi));
      chk("tx irq count", 32'h0, 32'(txi));
      chk("irq line", 32'h1, 32'(irq));
      wr(SBF_OFF_FCNF, 32'hD);
      line.strobe(3);
      repeat (3) @(posedge clock);
      chk("tx irq count", 32'h1, 32'(txi));
      rd(SBF_OFF_IRQ, 32'h3);
      wr(SBF_OFF_MASK, 32'h0);
      repeat (2) @(posedge clock);
      chk("irq masked", 32'h0, 32'(irq));
      wr(SBF_OFF_MASK, 32'h3);
      wr(SBF_OFF_IRQ, 32'h3);
      rd(SBF_OFF_IRQ, 32'h0);
      chk("irq cleared", 32'h0, 32'(irq));
      // auto disable per duplex; last pass has it off
      for (d = 0; d < 4; d++) begin
         dup = (d == 3) ? 2 : d;
         line.levels(1'b0, 1'b0);
         wr(SBF_OFF_CHAN, 32'h30 | (dup * 2));
         wr(SBF_OFF_FCNF, (d == 3) ? 32'h1 : 32'h3);
         if (d == 1) line.levels(1'b0, 1'b1);
         else line.levels(1'b1, 1'b0);
         repeat (3) @(posedge clock);
         chk("rx enable", 32'(d == 1 || d == 3), 32'(rx_enable));
         chk("tx enable", 32'(d == 0 || d == 3), 32'(tx_enable));
      end
      tally_and_finish();
   end
endmodule : tb
